// >>> common/slm_defines.vh
`ifndef SLM_DEFINES_VH
`define SLM_DEFINES_VH
// lane configuration codes
`define SLM_CFG_S8 5'h05
`define SLM_CFG_S4 5'h04
`define SLM_CFG_D4 5'h06
`define SLM_CFG_D8 5'h07
`define SLM_CFG_S16 5'h11
`define SLM_CFG_D16 5'h12
// power-mode values that keep serializers running
`define SLM_PMODE_RUN0 8'h00
`define SLM_PMODE_RUN1 8'h01
// lane test selection codes
`define SLM_TST_NORMAL 3'h0
`define SLM_TST_PRBS7 3'h1
`define SLM_TST_PRBS15 3'h2
`define SLM_TST_PRBS23 3'h3
`define SLM_TST_RAMP 3'h4
`define SLM_TST_STP 3'h5
// octet constants, frame divider and buffer depth
`define SLM_OCTET_RST 8'h00
`define SLM_ALL_ONES 8'hFF
`define SLM_FRAME_DIV 4
`define SLM_FIFO_DEPTH 16
`endif

// >>> src/slm_lane_mapper.v
// Functional notes
// - single eight-lane: even samples to link A lanes 0-3, odd to link B
// - dual four-lane: A0,A1 on link A lanes 0-1, B0,B1 on link B
// - dual eight-lane: Ai on link A lane i, Bi on link B lane i
// - single sixteen-lane: link A lane k gets S(2k), link B gets S(2k+1)
// - dual sixteen-lane: Ai on link A lane i, Bi on link B lane i
// - power-down pin high disables every lane driver and the converter
// - power mode other than 0x00 or 0x01 powers down all serializers
// - channel shutdown powers down the lanes of its link only; the converter stays up
// - unused highest-indexed lanes of each link are powered down
// - keep-alive keeps unused lanes powered, sending zero octets
// - test selection picks pattern; lane power does not depend on test selection
// - PRBS modes bypass the 8b/10b encoder
// - PRBS7 bit is XOR of bits 6 and 7 back, period 127
// - PRBS15 taps 14,15 period 32767; PRBS23 taps 18,23 period 8388607
// - each lane starts its PRBS from a distinct phase
// - ramp: after alignment every used lane sends same octet counting 0x00-0xFF
// - short transport pattern only, on enabled lowest lanes
// - transport pattern: frame 0 lane i sends i, frame 1 sends 0xFF-i
// - octets MSB first, tail bits zero
`timescale 1ns/1ps
`include "slm_defines.vh"

// ****************************************
// sample buffer
// ****************************************
module slm_fifo #(
  parameter W = 128,
  parameter D = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire rst_b,
  input wire [W-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [W-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0] count_r;
  wire push;
  wire pop;

  assign in_ready = (count_r != D[AW:0]);
  assign out_valid = (count_r != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_r] <= in_data;
  end

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_r <= (wr_ptr_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= (rd_ptr_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
      if (push && !pop)
        count_r <= count_r + 1'b1;
      else if (pop && !push)
        count_r <= count_r - 1'b1;
    end
  end
endmodule // slm_fifo

// ****************************************
// lane mapper and test generator
// ****************************************
module slm_lane_mapper #(
  parameter FRAME_DIV = `SLM_FRAME_DIV,
  parameter FIFO_DEPTH = `SLM_FIFO_DEPTH,
  parameter FIFO_AW = 4
) (
  input wire clk,
  input wire rst_b,
  input wire [127:0] samp_data,
  input wire samp_valid,
  output wire samp_ready,
  input wire link_ready,
  input wire ilas_done,
  input wire power_down_pin,
  input wire [7:0] power_mode,
  input wire chan_a_shutdown,
  input wire chan_b_shutdown,
  input wire [4:0] lane_config_select,
  input wire [2:0] lane_test_select,
  input wire spare_lane_keepalive_link_a,
  input wire spare_lane_keepalive_link_b,
  output reg [63:0] link_a_lanes,
  output reg [63:0] link_b_lanes,
  output reg [7:0] link_a_lane_pwr,
  output reg [7:0] link_b_lane_pwr,
  output reg lanes_valid,
  output reg encoder_bypass,
  output reg converter_pd
);
  // ****************************************
  // frame rate and buffer
  // ****************************************
  reg [7:0] div_r;
  reg frame_en_r;
  wire [127:0] buf_data;
  wire buf_valid;
  wire pop;
  wire is_normal;
  wire all_off;

  assign is_normal = (lane_test_select == `SLM_TST_NORMAL);
  // pops only when a frame slot is free
  assign pop = frame_en_r && link_ready && is_normal && !all_off;

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      div_r <= 8'h00;
      frame_en_r <= 1'b0;
    end
    else
    begin
      frame_en_r <= (div_r == FRAME_DIV[7:0] - 8'h01);
      div_r <= (div_r == FRAME_DIV[7:0] - 8'h01) ? 8'h00 : div_r + 8'h01;
    end
  end

  slm_fifo #(.W(128), .D(FIFO_DEPTH), .AW(FIFO_AW)) u_buf (
    .clk(clk),
    .rst_b(rst_b),
    .in_data(samp_data),
    .in_valid(samp_valid),
    .in_ready(samp_ready),
    .out_data(buf_data),
    .out_valid(buf_valid),
    .out_ready(pop)
  );

  // ****************************************
  // configuration decode and lane power
  // ****************************************
  reg [3:0] nlanes;
  reg dual;
  always @*
  begin
    nlanes = 4'h0;
    dual = 1'b0;
    case (lane_config_select)
      `SLM_CFG_S4: nlanes = 4'h2;
      `SLM_CFG_S8: nlanes = 4'h4;
      `SLM_CFG_D4:
      begin
        nlanes = 4'h2;
        dual = 1'b1;
      end
      `SLM_CFG_D8:
      begin
        nlanes = 4'h4;
        dual = 1'b1;
      end
      `SLM_CFG_S16: nlanes = 4'h8;
      `SLM_CFG_D16:
      begin
        nlanes = 4'h8;
        dual = 1'b1;
      end
      default: nlanes = 4'h0;
    endcase
  end

  // pin or power mode shuts everything
  assign all_off = power_down_pin ||
    !(power_mode == `SLM_PMODE_RUN0 || power_mode == `SLM_PMODE_RUN1);

  // ****************************************
  // pattern sources
  // ****************************************
  reg [7:0] ramp_r;
  reg stp_frame_r;
  reg [1:0] prbs_sel;
  wire prbs_mode;

  assign prbs_mode = (lane_test_select == `SLM_TST_PRBS7) ||
    (lane_test_select == `SLM_TST_PRBS15) || (lane_test_select == `SLM_TST_PRBS23);

  always @*
  begin
    case (lane_test_select)
      `SLM_TST_PRBS15: prbs_sel = 2'h1;
      `SLM_TST_PRBS23: prbs_sel = 2'h2;
      default: prbs_sel = 2'h0;
    endcase
  end

  // eight serial steps per frame; newest bit lands in bit 0
  function [22:0] prbs_step8;
    input [22:0] s;
    input [1:0] sel;
    reg [22:0] t;
    reg nb;
    integer n;
    begin
      t = s;
      for (n = 0; n < 8; n = n + 1)
      begin
        case (sel)
          2'h1: nb = t[13] ^ t[14];
          2'h2: nb = t[17] ^ t[22];
          default: nb = t[5] ^ t[6];
        endcase
        t = {t[21:0], nb};
      end
      prbs_step8 = t;
    end
  endfunction

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ramp_r <= `SLM_OCTET_RST;
      stp_frame_r <= 1'b0;
    end
    else if (frame_en_r)
    begin
      // ramp runs only after lane alignment
      if (lane_test_select == `SLM_TST_RAMP && ilas_done && link_ready)
        ramp_r <= ramp_r + 8'h01;
      else if (lane_test_select != `SLM_TST_RAMP)
        ramp_r <= `SLM_OCTET_RST;
      if (lane_test_select == `SLM_TST_STP)
        stp_frame_r <= ~stp_frame_r;
      else
        stp_frame_r <= 1'b0;
    end
  end

  // ****************************************
  // per-lane output
  // ****************************************
  genvar k;
  generate
    for (k = 0; k < 8; k = k + 1)
    begin : g_lane
      // lane index and seeds held as sized constants; genvars cannot be sliced
      localparam [7:0] LANE_ID = k;
      localparam [22:0] SEED_A = k + 1;
      localparam [22:0] SEED_B = k + 9;
      reg [22:0] prbs_a_r;
      reg [22:0] prbs_b_r;
      reg [7:0] oct_a;
      reg [7:0] oct_b;
      wire used;
      wire pwr_a;
      wire pwr_b;
      wire [7:0] stp_oct;

      assign used = ({4'h0, nlanes} > LANE_ID);
      assign pwr_a = !all_off && !chan_a_shutdown && (used || spare_lane_keepalive_link_a);
      assign pwr_b = !all_off && !chan_b_shutdown && (used || spare_lane_keepalive_link_b);
      // frame 0 sends i, frame 1 sends 0xFF-i
      assign stp_oct = stp_frame_r ? (`SLM_ALL_ONES - LANE_ID) : LANE_ID;

      always @*
      begin
        oct_a = `SLM_OCTET_RST;
        oct_b = `SLM_OCTET_RST;
        case (lane_test_select)
          `SLM_TST_NORMAL:
          begin
            // dual: channel A low half, B high half
            if (dual)
            begin
              oct_a = buf_data[8*k +: 8];
              oct_b = buf_data[64 + 8*k +: 8];
            end
            // single: even samples to link A, odd to link B
            else
            begin
              oct_a = buf_data[16*k +: 8];
              oct_b = buf_data[16*k + 8 +: 8];
            end
          end
          `SLM_TST_PRBS7, `SLM_TST_PRBS15, `SLM_TST_PRBS23:
          begin
            // first generated bit is the octet MSB
            oct_a = prbs_a_r[7:0];
            oct_b = prbs_b_r[7:0];
          end
          `SLM_TST_RAMP:
          begin
            oct_a = ramp_r;
            oct_b = ramp_r;
          end
          `SLM_TST_STP:
          begin
            oct_a = stp_oct;
            oct_b = stp_oct;
          end
          default:
          begin
            oct_a = `SLM_OCTET_RST;
            oct_b = `SLM_OCTET_RST;
          end
        endcase
      end

      always @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          prbs_a_r <= SEED_A;
          prbs_b_r <= SEED_B;
          link_a_lanes[8*k +: 8] <= `SLM_OCTET_RST;
          link_b_lanes[8*k +: 8] <= `SLM_OCTET_RST;
          link_a_lane_pwr[k] <= 1'b0;
          link_b_lane_pwr[k] <= 1'b0;
        end
        else
        begin
          link_a_lane_pwr[k] <= pwr_a;
          link_b_lane_pwr[k] <= pwr_b;
          if (frame_en_r)
          begin
            if (prbs_mode)
            begin
              prbs_a_r <= prbs_step8(prbs_a_r, prbs_sel);
              prbs_b_r <= prbs_step8(prbs_b_r, prbs_sel);
            end
            // unpowered or unused lanes send zero
            link_a_lanes[8*k +: 8] <= (pwr_a && used) ? oct_a : `SLM_OCTET_RST;
            link_b_lanes[8*k +: 8] <= (pwr_b && used) ? oct_b : `SLM_OCTET_RST;
          end
        end
      end
    end
  endgenerate

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lanes_valid <= 1'b0;
      encoder_bypass <= 1'b0;
      converter_pd <= 1'b0;
    end
    else
    begin
      // a normal frame needs buffered samples; tests run freely
      lanes_valid <= frame_en_r && !all_off && (is_normal ? (buf_valid && link_ready) : 1'b1);
      // raw bits to serializer in PRBS
      encoder_bypass <= prbs_mode;
      converter_pd <= all_off;
    end
  end
endmodule // slm_lane_mapper

// >>> test/slm_lane_mapper_checker.sv
`timescale 1ns/1ps
`include "slm_defines.vh"
// **********
// power and mode checks
// **********
module slm_lane_mapper_checker (
  input wire clk,
  input wire rst_b,
  input wire power_down_pin,
  input wire [7:0] power_mode,
  input wire chan_a_shutdown,
  input wire [4:0] lane_config_select,
  input wire [2:0] lane_test_select,
  input wire spare_lane_keepalive_link_a,
  input wire [7:0] link_a_lane_pwr,
  input wire [7:0] link_b_lane_pwr,
  input wire lanes_valid,
  input wire encoder_bypass,
  input wire converter_pd
);
  wire run_w = !power_down_pin && power_mode <= `SLM_PMODE_RUN1;
  wire a_on_w = run_w && !chan_a_shutdown;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_PIN_OFF: assert property (power_down_pin |=>
    link_a_lane_pwr == 8'h00 && link_b_lane_pwr == 8'h00 && converter_pd)
    else $error("lanes powered under pin power-down");
  AST_MODE_OFF: assert property (power_mode > `SLM_PMODE_RUN1 |=>
    converter_pd && link_b_lane_pwr == 8'h00)
    else $error("lanes powered under power mode");
  AST_RUN_ON: assert property (run_w |=> !converter_pd)
    else $error("converter down in run mode");
  AST_CHA_OFF: assert property (chan_a_shutdown |=> link_a_lane_pwr == 8'h00)
    else $error("link a powered under shutdown");
  AST_UNUSED: assert property (a_on_w && !spare_lane_keepalive_link_a &&
    lane_config_select == `SLM_CFG_S4 |=> link_a_lane_pwr == 8'h03)
    else $error("wrong lane power in four-lane mode");
  AST_KEEP: assert property (a_on_w && spare_lane_keepalive_link_a &&
    lane_config_select == `SLM_CFG_D8 |=> link_a_lane_pwr == 8'hFF)
    else $error("spare lanes not kept alive");
  AST_BYPASS: assert property (lane_test_select >= `SLM_TST_PRBS7 &&
    lane_test_select <= `SLM_TST_PRBS23 |-> ##[1:2] encoder_bypass)
    else $error("encoder not bypassed in prbs mode");
  AST_VALID_GAP: assert property (lanes_valid |=> !lanes_valid)
    else $error("frame strobe longer than one cycle");
  AST_PD_QUIET: assert property (converter_pd && $past(converter_pd) |-> !lanes_valid)
    else $error("frame sent while powered down");
endmodule // slm_lane_mapper_checker
bind slm_lane_mapper slm_lane_mapper_checker u_chk (.*);

// >>> test/slm_lane_mapper_tb_top.sv
`timescale 1ns/1ps
`include "slm_defines.vh"
module slm_lane_mapper_tb_top;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg [127:0] samp_data = 128'h0;
  reg samp_valid = 1'b0;
  reg ilas_done = 1'b1;
  reg power_down_pin = 1'b0;
  reg [7:0] power_mode = 8'h00;
  reg chan_a_shutdown = 1'b0;
  reg chan_b_shutdown = 1'b0;
  reg [4:0] lane_config_select = `SLM_CFG_D8;
  reg [2:0] lane_test_select = `SLM_TST_NORMAL;
  reg spare_lane_keepalive_link_a = 1'b0;
  reg spare_lane_keepalive_link_b = 1'b0;
  reg stall = 1'b0;
  wire samp_ready, link_ready, lanes_valid, encoder_bypass, converter_pd;
  wire [63:0] link_a_lanes, link_b_lanes;
  wire [7:0] link_a_lane_pwr, link_b_lane_pwr;
  wire [127:0] rx_frame;
  wire [15:0] rx_count;
  integer miscompares = 0, checks = 0, k, j;
  reg [127:0] w;
  reg [15:0] base;
  reg [7:0] sm [0:3];
  always #5 clk = ~clk;
  slm_lane_mapper #(.FRAME_DIV(4)) DUT (.*);
  slm_rx_model u_rx (.*);
  task stop_test;
  begin
    if (miscompares == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  task chk(input [127:0] seen, input [127:0] exp, input [79:0] nm);
  begin
    checks = checks + 1;
    if (seen !== exp)
    begin
      miscompares = miscompares + 1;
      $display("MISMATCH %0s expected %h seen %h", nm, exp, seen);
    end
  end
  endtask
  task hang(input integer n);
  begin
    if (n > 300)
    begin
      miscompares = miscompares + 1;
      stop_test;
    end
  end
  endtask
  task nxt;
  begin
    repeat (4) @(posedge clk);
    @(negedge clk);
  end
  endtask
  task send(input [127:0] d);
    integer n;
  begin
    samp_data <= d;
    samp_valid <= 1'b1;
    n = 0;
    @(negedge clk);
    while (samp_ready !== 1'b1)
    begin
      n = n + 1;
      hang(n);
      @(negedge clk);
    end
    @(posedge clk);
  end
  endtask
  task get_frame(input [15:0] tgt);
    integer n;
  begin
    n = 0;
    while (rx_count !== tgt)
    begin
      n = n + 1;
      hang(n);
      @(negedge clk);
    end
  end
  endtask
  task set_test(input [2:0] t);
  begin
    @(posedge clk);
    stall <= 1'b1;
    repeat (3) @(posedge clk);
    lane_test_select <= t;
    repeat (2) @(posedge clk);
    stall <= 1'b0;
    nxt;
    nxt;
  end
  endtask
  task pchk(input [16:0] x);
  begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({link_a_lane_pwr, link_b_lane_pwr, converter_pd}, x, "power");
    @(posedge clk);
  end
  endtask
  function [7:0] nx(input [23:0] h, input integer a, input integer b);
    reg [31:0] s;
    integer i;
  begin
    s = {h, 8'h00};
    for (i = 7; i >= 0; i = i - 1)
      s[i] = s[i + a] ^ s[i + b];
    nx = s[7:0];
  end
  endfunction
  function [127:0] exp_map(input integer c);
    integer i;
  begin
    exp_map = 128'h0;
    for (i = 0; i < (2 << (c / 2)); i = i + 1)
    begin
      exp_map[8 * i +: 8] = 8'hA0 + (c % 2 ? i : 2 * i);
      exp_map[64 + 8 * i +: 8] = 8'hA0 + (c % 2 ? 8 + i : 2 * i + 1);
    end
  end
  endfunction
  function [4:0] cfg_of(input integer c);
  begin
    case (c)
      0: cfg_of = `SLM_CFG_S4;
      1: cfg_of = `SLM_CFG_D4;
      2: cfg_of = `SLM_CFG_S8;
      3: cfg_of = `SLM_CFG_D8;
      4: cfg_of = `SLM_CFG_S16;
      default: cfg_of = `SLM_CFG_D16;
    endcase
  end
  endfunction
  initial
  begin
    for (j = 0; j < 16; j = j + 1)
      w[8 * j +: 8] = 8'hA0 + j;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    power_down_pin <= 1'b1;
    pchk({16'h0000, 1'b1});
    power_down_pin <= 1'b0;
    power_mode <= 8'h02;
    pchk({16'h0000, 1'b1});
    power_mode <= `SLM_PMODE_RUN1;
    chan_a_shutdown <= 1'b1;
    pchk({16'h000F, 1'b0});
    chan_a_shutdown <= 1'b0;
    chan_b_shutdown <= 1'b1;
    spare_lane_keepalive_link_a <= 1'b1;
    pchk({16'hFF00, 1'b0});
    chan_b_shutdown <= 1'b0;
    spare_lane_keepalive_link_b <= 1'b1;
    pchk({16'hFFFF, 1'b0});
    spare_lane_keepalive_link_a <= 1'b0;
    spare_lane_keepalive_link_b <= 1'b0;
    power_mode <= `SLM_PMODE_RUN0;
    lane_config_select <= `SLM_CFG_D16;
    for (k = 1; k < 6; k = k + 1)
    begin
      set_test(k[2:0]);
      for (j = 0; j < 4; j = j + 1)
      begin
        sm[j] = link_a_lanes[15:8];
        if (j < 3)
          nxt;
      end
      if (k < 4)
      begin
        chk({encoder_bypass, link_a_lanes == link_b_lanes}, 2'b10, "prbs_mode");
        chk(sm[3], nx({sm[0], sm[1], sm[2]}, k == 1 ? 6 : k == 2 ? 14 : 18,
          k == 1 ? 7 : k == 2 ? 15 : 23), "prbs");
      end
      else if (k == 4)
      begin
        chk(encoder_bypass, 1'b0, "bypass");
        chk({link_a_lanes, link_b_lanes}, {16{sm[3]}}, "ramp");
        chk({sm[0] + 8'h03}, sm[3], "ramp_step");
      end
      else
      begin
        chk(sm[1], {~sm[0]}, "stp_flip");
        chk({link_a_lanes, link_b_lanes}, {2{sm[3] == 8'h01 ?
          64'h0706050403020100 : ~64'h0706050403020100}}, "stp");
      end
    end
    set_test(`SLM_TST_NORMAL);
    for (k = 0; k < 6; k = k + 1)
    begin
      @(posedge clk);
      lane_config_select <= cfg_of(k);
      base = rx_count;
      send(w);
      samp_valid <= 1'b0;
      get_frame(base + 16'h0001);
      chk(rx_frame, exp_map(k), "lanes");
      chk(link_b_lane_pwr, 8'hFF >> (8 - (2 << (k / 2))), "lane_pwr");
    end
    @(posedge clk);
    lane_config_select <= `SLM_CFG_S8;
    stall <= 1'b1;
    repeat (3) @(posedge clk);
    base = rx_count;
    for (k = 0; k < 16; k = k + 1)
      send({16{8'h40 + k[7:0]}});
    samp_data <= {16{8'h99}};
    repeat (8) @(posedge clk);
    samp_valid <= 1'b0;
    @(negedge clk);
    chk(samp_ready, 1'b0, "full");
    @(posedge clk);
    stall <= 1'b0;
    for (k = 0; k < 16; k = k + 1)
    begin
      get_frame(base + k[15:0] + 16'h0001);
      chk(rx_frame[15:0], {2{8'h40 + k[7:0]}}, "order");
      if (k == 7)
      begin
        @(posedge clk);
        stall <= 1'b1;
        repeat (20) @(posedge clk);
        stall <= 1'b0;
      end
    end
    repeat (40) @(posedge clk);
    @(negedge clk);
    chk(rx_count, base + 16'h0010, "refused");
    stop_test;
  end
endmodule // slm_lane_mapper_tb_top

// >>> test/slm_rx_model.sv
`timescale 1ns/1ps
// **********
// far-end receiver
// **********
module slm_rx_model (
  input wire clk,
  input wire rst_b,
  input wire stall,
  input wire converter_pd,
  input wire lanes_valid,
  input wire [63:0] link_a_lanes,
  input wire [63:0] link_b_lanes,
  output reg link_ready,
  output reg [127:0] rx_frame,
  output reg [15:0] rx_count
);
  reg pd_r;
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      link_ready <= 1'b0;
      pd_r <= 1'b0;
      rx_frame <= 128'h0;
      rx_count <= 16'h0000;
    end
    else
    begin
      pd_r <= converter_pd;
      // stale data dropped one more cycle
      link_ready <= !stall && !converter_pd && !pd_r;
      if (lanes_valid && !pd_r)
      begin
        rx_frame <= {link_b_lanes, link_a_lanes};
        rx_count <= rx_count + 16'h0001;
      end
    end
  end
endmodule // slm_rx_model
